// File: core/csr_setpoint_bank.sv
`timescale 1ns/100ps
`include "csr_regs.svh"
module csr_setpoint_bank
   import csr_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = `CSR_BLANK_CYCLES
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // register port
   input  wire logic       wr_en_in,
   input  wire logic       rd_en_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] rdata_out,
   output logic            rdata_valid_out,
   // password state and resistor preset
   input  wire logic       unlocked_in,
   input  wire logic       preset_valid_in,
   input  wire logic [5:0] preset_buck3_in,
   input  wire logic [5:0] preset_buckboost_in,
   // converter controls and status
   output logic      [5:0] buck3_setpoint_out,
   output logic            buck3_skip_out,
   output logic      [5:0] buckboost_setpoint_out,
   output logic            buckboost_skip_out,
   output logic      [5:0] buck2_setpoint_out,
   output logic            buck2_skip_out,
   output logic            monitor_blank_out,
   output logic            wr_rejected_out
);
   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   // zero would wrap the counter and blank for about four billion cycles
   if (BLANK_CYCLES < 1) begin : g_bad_blank
      $error("BLANK_CYCLES must be at least 1");
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic hit_b3;
   logic hit_bb;
   logic hit_b2;
   logic hit_any;
   logic wr_ok;
   logic any_wr;
   logic preset_load;
   logic preset_done;
   logic [7:0] val_b3;
   logic [7:0] val_bb;
   logic [7:0] val_b2;
   logic wr_b3;
   logic wr_bb;
   logic wr_b2;
   logic [7:0] next_rdata;

   assign hit_b3 = (addr_in == `CSR_ADDR_BUCK3);
   assign hit_bb = (addr_in == `CSR_ADDR_BUCKBOOST);
   assign hit_b2 = (addr_in == `CSR_ADDR_BUCK2);
   // writes to unmapped subaddresses neither store nor blank
   assign hit_any = hit_b3 || hit_bb || hit_b2;
   // locked writes are dropped, never partially applied
   assign wr_ok  = wr_en_in && unlocked_in;
   assign any_wr = wr_ok && hit_any;
   // one write strobe per register, at most one high in a cycle
   assign wr_b3  = wr_ok && hit_b3;
   assign wr_bb  = wr_ok && hit_bb;
   assign wr_b2  = wr_ok && hit_b2;
   // limitation: a buck3 or buck-boost write in the preset cycle loses its data but still
   // blanks, so hosts should wait one cycle after reset before writing
   assign preset_load = preset_valid_in && !preset_done;

   // resistor preset taken once, first cycle it is valid after reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         preset_done <= 1'b0;
      end else if (preset_valid_in) begin
         preset_done <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   csr_setpoint_reg #(.RESET_VAL(`CSR_RST_BUCK3)) u_buck3 (
      .clk_in         (clk_in),
      .nrst_in        (nrst_in),
      .preset_load_in (preset_load),
      .preset_code_in (preset_buck3_in),
      .wr_in          (wr_b3),
      .wdata_in       (wdata_in),
      .value_out      (val_b3)
   );

   // the host keeps codes at or below 34h and writes only while stopped
   csr_setpoint_reg #(.RESET_VAL(`CSR_RST_BUCKBOOST)) u_bb (
      .clk_in         (clk_in),
      .nrst_in        (nrst_in),
      .preset_load_in (preset_load),
      .preset_code_in (preset_buckboost_in),
      .wr_in          (wr_bb),
      .wdata_in       (wdata_in),
      .value_out      (val_bb)
   );

   // buck2 has no resistor preset
   csr_setpoint_reg #(.RESET_VAL(`CSR_RST_BUCK2)) u_buck2 (
      .clk_in         (clk_in),
      .nrst_in        (nrst_in),
      .preset_load_in (1'b0),
      .preset_code_in (6'h00),
      .wr_in          (wr_b2),
      .wdata_in       (wdata_in),
      .value_out      (val_b2)
   );

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // one cycle behind the register so each converter sees a clean flop
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         buck3_setpoint_out     <= 6'h0c;
         buck3_skip_out         <= 1'b1;
         buckboost_setpoint_out <= 6'h32;
         buckboost_skip_out     <= 1'b1;
         buck2_setpoint_out     <= 6'h19;
         buck2_skip_out         <= 1'b1;
      end else begin
         buck3_setpoint_out     <= val_b3[`CSR_VSET_MSB:0];
         buck3_skip_out         <= val_b3[`CSR_SKIP_BIT];
         buckboost_setpoint_out <= val_bb[`CSR_VSET_MSB:0];
         buckboost_skip_out     <= val_bb[`CSR_SKIP_BIT];
         buck2_setpoint_out     <= val_b2[`CSR_VSET_MSB:0];
         buck2_skip_out         <= val_b2[`CSR_SKIP_BIT];
      end
   end

   // read mux; unmapped subaddresses return zero so probing is harmless
   always_comb begin
      case (addr_in)
         `CSR_ADDR_BUCK3:     next_rdata = val_b3;
         `CSR_ADDR_BUCKBOOST: next_rdata = val_bb;
         `CSR_ADDR_BUCK2:     next_rdata = val_b2;
         default:             next_rdata = 8'h00;
      endcase
   end

   // read data one cycle after the strobe, held until the next read
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out       <= 8'h00;
         rdata_valid_out <= 1'b0;
      end else begin
         rdata_valid_out <= rd_en_in;
         if (rd_en_in) begin
            rdata_out <= next_rdata;
         end
      end
   end

   // one-cycle pulse when a mapped write is refused while locked
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_rejected_out <= 1'b0;
      end else begin
         wr_rejected_out <= wr_en_in && !unlocked_in && hit_any;
      end
   end

   // ----------------------------------------------------------------
   // monitor blanking
   // ----------------------------------------------------------------
   csr_mon_state_t mon_state;
   logic [31:0]    blank_cnt;

   // a new write restarts the full interval, so the window always covers it
   // locked writes change nothing at a converter, so they do not blank
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mon_state         <= CSR_MON_ACTIVE;
         blank_cnt         <= 32'h0;
         monitor_blank_out <= 1'b0;
      end else begin
         case (mon_state)
            CSR_MON_ACTIVE: begin
               if (any_wr) begin
                  mon_state         <= CSR_MON_BLANK;
                  blank_cnt         <= BLANK_CYCLES - 1;
                  monitor_blank_out <= 1'b1;
               end
            end
            CSR_MON_BLANK: begin
               if (any_wr) begin
                  blank_cnt <= BLANK_CYCLES - 1;
               end else if (blank_cnt == 32'h0) begin
                  mon_state         <= CSR_MON_ACTIVE;
                  monitor_blank_out <= 1'b0;
               end else begin
                  blank_cnt <= blank_cnt - 32'h1;
               end
            end
            default: begin
               mon_state         <= CSR_MON_ACTIVE;
               monitor_blank_out <= 1'b0;
            end
         endcase
      end
   end
endmodule : csr_setpoint_bank

// File: core/csr_regs.svh
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH
// register subaddresses
`define CSR_ADDR_BUCK3       8'h18
`define CSR_ADDR_BUCKBOOST   8'h19
`define CSR_ADDR_BUCK2       8'h17
// field positions
`define CSR_SKIP_BIT         7
`define CSR_RSVD_BIT         6
`define CSR_VSET_MSB         5
// reset values
`define CSR_RST_BUCK3        8'h8c
`define CSR_RST_BUCKBOOST    8'hb2
`define CSR_RST_BUCK2        8'h99
// highest legal buck-boost code
`define CSR_BB_MAX_CODE      6'h34
// blanking time
`define CSR_BLANK_MS         5
`define CSR_CLK_KHZ          100000
`define CSR_BLANK_CYCLES     (`CSR_BLANK_MS * `CSR_CLK_KHZ)
`endif

// File: core/csr_pkg.sv
package csr_pkg;
   typedef enum logic [0:0] {
      CSR_MON_ACTIVE = 1'b0,
      CSR_MON_BLANK  = 1'b1
   } csr_mon_state_t;
endpackage : csr_pkg

// File: core/csr_setpoint_reg.sv
`timescale 1ns/100ps
`include "csr_regs.svh"
// one converter control register: skip bit, reserved bit 6, 6-bit set-point
module csr_setpoint_reg
   import csr_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // preset load at reset release
   input  wire logic       preset_load_in,
   input  wire logic [5:0] preset_code_in,
   // write port
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   // contents
   output logic      [7:0] value_out
);
   logic skip;
   logic [5:0] code;

   // storage; a preset reaching the set-point only, skip keeps its default
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         skip <= RESET_VAL[`CSR_SKIP_BIT];
         code <= RESET_VAL[`CSR_VSET_MSB:0];
      end else if (preset_load_in) begin
         code <= preset_code_in;
      end else if (wr_in) begin
         skip <= wdata_in[`CSR_SKIP_BIT];
         code <= wdata_in[`CSR_VSET_MSB:0];
      end
   end

   // bit 6 always reads zero
   assign value_out = {skip, 1'b0, code};
endmodule : csr_setpoint_reg

// File: testbench/csr_setpoint_bank_chk.sv
`timescale 1ns/100ps
module csr_setpoint_bank_chk #(
   parameter int unsigned BLANK_CYCLES = 20
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // register port
   input  wire logic       wr_en_in,
   input  wire logic       rd_en_in,
   input  wire logic       unlocked_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic [7:0] rdata_out,
   input  wire logic       rdata_valid_out,
   // status and converter controls
   input  wire logic       monitor_blank_out,
   input  wire logic       wr_rejected_out,
   input  wire logic [5:0] buck3_setpoint_out,
   input  wire logic [5:0] buckboost_setpoint_out,
   input  wire logic       buck3_skip_out,
   input  wire logic       buckboost_skip_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic        mapped, wr_ok;
   int unsigned since;
   assign mapped = addr_in inside {8'h17, 8'h18, 8'h19};
   assign wr_ok  = wr_en_in && unlocked_in && mapped;
   // cycles since last taken write, saturating so it never wraps
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) since <= BLANK_CYCLES + 2;
      else if (wr_ok) since <= 0;
      else if (since < BLANK_CYCLES + 2) since <= since + 1;
   end
   a_blank_starts: assert property (wr_ok |=> monitor_blank_out [*8])
      else $error("blank missing after write");
   a_blank_length: assert property (monitor_blank_out == (since < BLANK_CYCLES))
      else $error("blank length wrong");
   a_lock_refuse: assert property (wr_rejected_out ==
      $past(wr_en_in && !unlocked_in && mapped)) else $error("reject pulse wrong");
   a_buck3_write: assert property (wr_ok && addr_in == 8'h18 |-> ##2
      buck3_setpoint_out == $past(wdata_in[5:0], 2) && buck3_skip_out == $past(wdata_in[7], 2))
      else $error("buck3 output wrong");
   a_bb_write: assert property (wr_ok && addr_in == 8'h19 |-> ##2
      buckboost_setpoint_out == $past(wdata_in[5:0], 2) &&
      buckboost_skip_out == $past(wdata_in[7], 2)) else $error("bb output wrong");
   a_rsvd_zero: assert property (rd_en_in && mapped |=>
      rdata_valid_out && !rdata_out[6]) else $error("bit 6 reads one");
   a_unmapped_zero: assert property (rd_en_in && !mapped |=> rdata_valid_out && rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_reset_vals: assert property (!$past(nrst_in) |->
      buck3_setpoint_out == 6'h0c && buckboost_setpoint_out == 6'h32 &&
      buck3_skip_out && buckboost_skip_out) else $error("reset outputs wrong");
endmodule : csr_setpoint_bank_chk
bind csr_setpoint_bank csr_setpoint_bank_chk #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (
   .clk_in(clk_in), .nrst_in(nrst_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
   .unlocked_in(unlocked_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
   .rdata_valid_out(rdata_valid_out), .monitor_blank_out(monitor_blank_out),
   .wr_rejected_out(wr_rejected_out), .buck3_setpoint_out(buck3_setpoint_out),
   .buckboost_setpoint_out(buckboost_setpoint_out), .buck3_skip_out(buck3_skip_out),
   .buckboost_skip_out(buckboost_skip_out));

// File: testbench/csr_host_model.sv
`timescale 1ns/100ps
module csr_host_model (
   // clock and read return
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   input  wire logic       rdata_valid_in,
   // register port and password state
   output logic            wr_en_out,
   output logic            rd_en_out,
   output logic            unlocked_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out
);
   initial {wr_en_out, rd_en_out, unlocked_out, addr_out, wdata_out} = '0;
   // password state held by the host
   task lock(input logic u);
      @(posedge clk_in);
      unlocked_out <= u;
   endtask : lock
   // one strobe per byte; released lines flip so no stale value lingers
   task wr(input logic [7:0] a, d);
      @(posedge clk_in);
      wr_en_out <= 1'b1;
      addr_out  <= a;
      wdata_out <= (a == 8'h19 && d[5:0] > 6'h34) ? {d[7:6], 6'h34} : d;
      @(posedge clk_in);
      wr_en_out <= 1'b0;
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      rd_en_out <= 1'b1;
      addr_out  <= a;
      @(posedge clk_in);
      rd_en_out <= 1'b0;
      addr_out  <= ~a;
      @(posedge clk_in);
      // data only counts while the valid pulse stands
      d = rdata_valid_in ? rdata_in : 8'hxx;
   endtask : rd
endmodule : csr_host_model

// File: testbench/csr_setpoint_bank_test.sv
`timescale 1ns/100ps
module csr_setpoint_bank_test;
   logic       clk_in = 1'b0, nrst_in = 1'b0, pv = 1'b1, wr, rd, ul, rv, b3s, bbs, b2s, bl, rj, lk;
   logic [5:0] p3, pb, b3, bb, b2;
   logic [7:0] ad, wd, rdat, got, a, d;
   logic [7:0] shadow [8'h17:8'h19];
   logic [7:0] corner [4] = '{8'hc0, 8'hff, 8'h7f, 8'h00};
   int         n_errors = 0, n_tests = 0, seed = 53, cyc = 0;
   always #5 clk_in = ~clk_in;
   csr_setpoint_bank #(.BLANK_CYCLES(20)) u_csr_setpoint_bank (.clk_in(clk_in),
      .nrst_in(nrst_in), .wr_en_in(wr), .rd_en_in(rd), .addr_in(ad), .wdata_in(wd),
      .rdata_out(rdat), .rdata_valid_out(rv), .unlocked_in(ul), .preset_valid_in(pv),
      .preset_buck3_in(p3), .preset_buckboost_in(pb), .buck3_setpoint_out(b3),
      .buck3_skip_out(b3s), .buckboost_setpoint_out(bb), .buckboost_skip_out(bbs),
      .buck2_setpoint_out(b2), .buck2_skip_out(b2s), .monitor_blank_out(bl),
      .wr_rejected_out(rj));
   csr_host_model u_csr_host_model (.clk_in(clk_in), .rdata_in(rdat), .rdata_valid_in(rv),
      .wr_en_out(wr),
      .rd_en_out(rd), .unlocked_out(ul), .addr_out(ad), .wdata_out(wd));
   // bit 6 never stored, reserved buck-boost codes never sent
   function automatic logic [7:0] exp_reg(input logic [7:0] a, d);
      return {d[7], 1'b0, (a == 8'h19 && d[5:0] > 6'h34) ? 6'h34 : d[5:0]};
   endfunction : exp_reg
   task chk(input string what, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk
   task give_verdict;
      $display("errors %0d, checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // hang guard, well above the roughly 320 cycles used
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge clk_in);
      // preset codes only matter once reset lets go; no reserved bb codes
      p3 <= 6'($random(seed));
      pb <= 6'($unsigned($random(seed)) % 53);
      chk("buck3 reset", 8'h8c, {b3s, 1'b0, b3});
      chk("bb reset", 8'hb2, {bbs, 1'b0, bb});
      repeat (6) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      shadow[8'h17] = 8'h99;
      shadow[8'h18] = {2'b10, p3};
      shadow[8'h19] = {2'b10, pb};
      for (a = 8'h17; a <= 8'h1a; a++) begin
         u_csr_host_model.rd(a, got);
         chk("read", (a == 8'h1a) ? 8'h00 : shadow[a], got);
      end
      for (int i = 0; i < 40; i++) begin
         a  = (i < 4) ? 8'(8'h17 + i % 3) : 8'(8'h17 + $unsigned($random(seed)) % 3);
         d  = (i < 4) ? corner[i] : 8'($random(seed));
         lk = (i < 4) || $random(seed) % 3 != 0;
         u_csr_host_model.lock(lk);
         u_csr_host_model.wr(a, d);
         if (lk) shadow[a] = exp_reg(a, d);
         u_csr_host_model.rd(a, got);
         chk("readback", shadow[a], got);
         chk("buck3 out", shadow[8'h18], {b3s, 1'b0, b3});
         chk("bb out", shadow[8'h19], {bbs, 1'b0, bb});
         chk("buck2 out", shadow[8'h17], {b2s, 1'b0, b2});
      end
      repeat (30) @(posedge clk_in);
      u_csr_host_model.lock(1'b0);
      u_csr_host_model.wr(8'h19, 8'h05);
      @(posedge clk_in);
      chk("rejected", 8'h01, {7'h0, rj});
      chk("blank idle", 8'h00, {7'h0, bl});
      u_csr_host_model.lock(1'b1);
      u_csr_host_model.wr(8'h18, 8'h85);
      @(posedge clk_in);
      chk("blank on", 8'h01, {7'h0, bl});
      // 20-cycle interval: still high 20 edges on, low one edge later
      repeat (19) @(posedge clk_in);
      chk("blank held", 8'h01, {7'h0, bl});
      @(posedge clk_in);
      chk("blank off", 8'h00, {7'h0, bl});
      give_verdict();
   end
endmodule : csr_setpoint_bank_test
